// ### rtl/chip_settings_readback.sv
// chip-settings readback: builds the read-settings reply and applies settings
// assumes a byte register port, reply read through the reply window,
// and clk standing in for the internal usb clock
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module chip_settings_readback (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // activity and status inputs
  input  wire logic       uart_rx_active,
  input  wire logic       uart_tx_active,
  input  wire logic       i2c_active,
  input  wire logic       usb_suspended,
  input  wire logic       usb_configured,
  // pin function enables
  input  wire logic       i2c_indicator_en,
  input  wire logic       suspend_indicator_en,
  input  wire logic       configured_indicator_en,
  input  wire logic       clock_out_en,
  // password checked elsewhere
  input  wire logic       password_ok,
  // indicator pins
  output logic            rx_activity_indicator,
  output logic            tx_activity_indicator,
  output logic            i2c_activity_indicator,
  output logic            suspend_indicator,
  output logic            configured_indicator,
  // clock reference pin
  output logic            clock_ref_out,
  // enumeration and security
  output logic            serial_number_enable,
  output logic            config_locked,
  output logic            config_password_mode,
  output logic            settings_write_blocked,
  // dac control
  output logic      [1:0] dac_ref_level,
  output logic            dac_ref_internal,
  output logic      [4:0] dac_value
);

  // ****************************************
  // state and wires
  // ****************************************
  chip_settings_pkg::build_state_t state_q;
  chip_settings_pkg::build_state_t state_d;

  logic [7:0] req_cmd_q;
  logic [7:0] req_sub_q;
  logic [7:0] set4_q;
  logic [7:0] set5_q;
  logic [7:0] set6_q;
  logic [2:0] idx_q;
  logic       ready_q;
  logic       power_up_q;
  logic [4:0] div_cnt_q;
  logic [7:0] reg_rdata_q;
  logic       win_sel_q;

  logic [7:0] rx_q;
  logic [7:0] ctrl_rd;
  logic       sel_window;
  logic       sel_cmd;
  logic       sel_sub;
  logic       sel_s4;
  logic       sel_s5;
  logic       sel_s6;
  logic       sel_ctrl;
  logic       go;
  logic       sec_locked;
  logic       sec_pw;
  logic       set_wr_ok;
  logic       supported;
  logic       busy;
  logic [7:0] byte_val;
  logic [4:0] div_val;
  logic       div_hit;

  reply_buf_if buf_bus ();

  reply_buf u_reply_buf (
    .clk      (clk),
    .reset_n  (reset_n),
    .buf_port (buf_bus.mem)
  );

  // ****************************************
  // address decode
  // ****************************************

  // one select per register
  assign sel_window = (reg_addr[3] == chip_settings_pkg::REPLY_BASE[3]);
  assign sel_cmd    = (reg_addr == chip_settings_pkg::REQ_CMD);
  assign sel_sub    = (reg_addr == chip_settings_pkg::REQ_SUB);
  assign sel_s4     = (reg_addr == chip_settings_pkg::SET_BYTE4);
  assign sel_s5     = (reg_addr == chip_settings_pkg::SET_BYTE5);
  assign sel_s6     = (reg_addr == chip_settings_pkg::SET_BYTE6);
  assign sel_ctrl   = (reg_addr == chip_settings_pkg::CTRL_STATUS);
  assign busy       = (state_q != chip_settings_pkg::ST_IDLE);
  assign go         = reg_wr && sel_ctrl && reg_wdata[0] && !busy;

  // ****************************************
  // security mode
  // ****************************************

  // locked when the upper bit is set, password when only the low bit is
  assign sec_locked = set4_q[chip_settings_pkg::SEC_HI];
  assign sec_pw     = (set4_q[chip_settings_pkg::SEC_HI:0]
                       == chip_settings_pkg::SEC_PASSWORD);
  assign set_wr_ok  = !sec_locked && (!sec_pw || password_ok);

  // ****************************************
  // request and settings registers
  // ****************************************

  // request bytes are always writable
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      req_cmd_q <= 8'h00;
      req_sub_q <= 8'h00;
    end
    else
    begin
      if (reg_wr && sel_cmd)
        req_cmd_q <= reg_wdata;
      if (reg_wr && sel_sub)
        req_sub_q <= reg_wdata;
    end
  end

  // stored settings, writes dropped while secured
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      set4_q <= chip_settings_pkg::SET4_RST;
      set5_q <= chip_settings_pkg::SET5_RST;
      set6_q <= chip_settings_pkg::SET6_RST;
    end
    else if (reg_wr && set_wr_ok)
    begin
      if (sel_s4)
        set4_q <= reg_wdata;
      if (sel_s5)
        set5_q <= reg_wdata & chip_settings_pkg::DIV_MASK;
      if (sel_s6)
        set6_q <= reg_wdata;
    end
  end

  // ****************************************
  // reply builder
  // ****************************************

  // only the read command with the chip-settings sub-code is answered in full
  assign supported = (req_cmd_q == chip_settings_pkg::CMD_READ_FLASH)
                  && (req_sub_q == chip_settings_pkg::SUB_CHIP_SET);

  // byte for the current index; unlisted bytes are zero
  always_comb
  begin
    byte_val = 8'h00;
    case (idx_q)
      chip_settings_pkg::IDX_CMD:
        byte_val = req_cmd_q;
      chip_settings_pkg::IDX_CODE:
        byte_val = supported ? chip_settings_pkg::CODE_OK
                             : chip_settings_pkg::CODE_UNSUPPORTED;
      chip_settings_pkg::IDX_LEN:
        byte_val = supported ? chip_settings_pkg::RECORD_LEN : 8'h00;
      chip_settings_pkg::IDX_B4:
        byte_val = supported ? set4_q : 8'h00;
      chip_settings_pkg::IDX_B5:
        byte_val = supported ? (set5_q & chip_settings_pkg::DIV_MASK) : 8'h00;
      chip_settings_pkg::IDX_B6:
        byte_val = supported ? set6_q : 8'h00;
      default:
        byte_val = 8'h00;
    endcase
  end

  // next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      chip_settings_pkg::ST_IDLE:
        if (go)
          state_d = chip_settings_pkg::ST_BUILD;
      chip_settings_pkg::ST_BUILD:
        if (idx_q == chip_settings_pkg::LAST_BYTE)
          state_d = chip_settings_pkg::ST_DONE;
      chip_settings_pkg::ST_DONE:
        state_d = chip_settings_pkg::ST_IDLE;
      default:
        state_d = chip_settings_pkg::ST_IDLE;
    endcase
  end

  // state, byte index and ready flag
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_q <= chip_settings_pkg::ST_IDLE;
      idx_q   <= 3'h0;
      ready_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      idx_q   <= (state_q == chip_settings_pkg::ST_BUILD) ? idx_q + 3'h1 : 3'h0;
      if (state_q == chip_settings_pkg::ST_DONE)
        ready_q <= 1'b1;
      else if (go)
        ready_q <= 1'b0;
    end
  end

  // buffer writes during build, reads from the reply window
  assign buf_bus.wr_en   = (state_q == chip_settings_pkg::ST_BUILD);
  assign buf_bus.wr_addr = idx_q;
  assign buf_bus.wr_data = byte_val;
  assign buf_bus.rd_en   = reg_rd && sel_window;
  assign buf_bus.rd_addr = reg_addr[2:0];

  // ****************************************
  // read path
  // ****************************************

  // status: bit0 busy, bit1 reply ready
  assign ctrl_rd = {6'h00, ready_q, busy};

  // register read mux, unmapped reads give zero
  always_comb
  begin
    rx_q = 8'h00;
    if (sel_cmd)
      rx_q = req_cmd_q;
    else if (sel_sub)
      rx_q = req_sub_q;
    else if (sel_s4)
      rx_q = set4_q;
    else if (sel_s5)
      rx_q = set5_q;
    else if (sel_s6)
      rx_q = set6_q;
    else if (sel_ctrl)
      rx_q = ctrl_rd;
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      reg_rdata_q <= 8'h00;
      win_sel_q   <= 1'b0;
    end
    else
    begin
      reg_rdata_q <= reg_rd ? rx_q : 8'h00;
      win_sel_q   <= reg_rd && sel_window;
    end
  end

  assign reg_rdata = win_sel_q ? buf_bus.rd_data : reg_rdata_q;

  // ****************************************
  // indicator pins
  // ****************************************

  // idle level from the settings, inverted while the condition holds
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rx_activity_indicator  <= 1'b0;
      tx_activity_indicator  <= 1'b0;
      i2c_activity_indicator <= 1'b0;
      suspend_indicator      <= 1'b0;
      configured_indicator   <= 1'b0;
    end
    else
    begin
      rx_activity_indicator  <= set4_q[chip_settings_pkg::RX_BIT] ^ uart_rx_active;
      tx_activity_indicator  <= set4_q[chip_settings_pkg::TX_BIT] ^ uart_tx_active;
      i2c_activity_indicator <= set4_q[chip_settings_pkg::I2C_BIT]
                                ^ (i2c_indicator_en && i2c_active);
      suspend_indicator      <= set4_q[chip_settings_pkg::SUSP_BIT]
                                ^ (suspend_indicator_en && usb_suspended);
      configured_indicator   <= set4_q[chip_settings_pkg::CFG_BIT]
                                ^ (configured_indicator_en && usb_configured);
    end
  end

  // ****************************************
  // enumeration and security outputs
  // ****************************************

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      serial_number_enable   <= 1'b0;
      config_locked          <= 1'b0;
      config_password_mode   <= 1'b0;
      settings_write_blocked <= 1'b0;
    end
    else
    begin
      serial_number_enable   <= set4_q[chip_settings_pkg::SERIAL_BIT];
      config_locked          <= sec_locked;
      config_password_mode   <= sec_pw;
      settings_write_blocked <= !set_wr_ok;
    end
  end

  // ****************************************
  // clock reference divider
  // ****************************************

  // toggle every divider+1 cycles; held low when the pin is not a clock output
  assign div_val = set5_q[chip_settings_pkg::DIV_HI:0];
  assign div_hit = (div_cnt_q >= div_val);

  always_ff @(posedge clk)
  begin
    if (!reset_n || !clock_out_en)
    begin
      div_cnt_q     <= 5'h00;
      clock_ref_out <= 1'b0;
    end
    else if (div_hit)
    begin
      div_cnt_q     <= 5'h00;
      clock_ref_out <= !clock_ref_out;
    end
    else
      div_cnt_q <= div_cnt_q + 5'h01;
  end

  // ****************************************
  // dac settings
  // ****************************************

  // reference follows the settings; value loaded once after reset
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      dac_ref_level    <= 2'h0;
      dac_ref_internal <= 1'b0;
      dac_value        <= 5'h00;
      power_up_q       <= 1'b1;
    end
    else
    begin
      dac_ref_level    <= set6_q[chip_settings_pkg::REF_HI:chip_settings_pkg::REF_LO];
      dac_ref_internal <= set6_q[chip_settings_pkg::REF_SRC];
      power_up_q       <= 1'b0;
      if (power_up_q)
        dac_value <= set6_q[chip_settings_pkg::DAC_HI:0];
    end
  end

endmodule
`default_nettype wire

// ### include/chip_settings_pkg.sv
// constants for the chip-settings readback block
// assumes a byte-wide register port and a 100 MHz clk
`default_nettype none
package chip_settings_pkg;

  // register port offsets
  localparam logic [3:0] REPLY_BASE   = 4'h0; // 0x0-0x7 reply window, read only
  localparam logic [3:0] REQ_CMD      = 4'h8; // request byte 0
  localparam logic [3:0] REQ_SUB      = 4'h9; // request byte 1, sub-code
  localparam logic [3:0] SET_BYTE4    = 4'hA; // indicator levels and security
  localparam logic [3:0] SET_BYTE5    = 4'hB; // clock divider
  localparam logic [3:0] SET_BYTE6    = 4'hC; // dac settings
  localparam logic [3:0] CTRL_STATUS  = 4'hD; // w: bit0 go; r: bit0 busy, bit1 ready

  // reply bytes
  localparam logic [7:0] CMD_READ_FLASH  = 8'hB0;
  localparam logic [7:0] SUB_CHIP_SET    = 8'h00;
  localparam logic [7:0] CODE_OK         = 8'h00;
  localparam logic [7:0] CODE_UNSUPPORTED = 8'h01;
  localparam logic [7:0] RECORD_LEN      = 8'h07; // bytes 0..6 of the record
  localparam logic [2:0] LAST_BYTE       = 3'h6;
  localparam logic [2:0] IDX_CMD         = 3'h0;
  localparam logic [2:0] IDX_CODE        = 3'h1;
  localparam logic [2:0] IDX_LEN         = 3'h2;
  localparam logic [2:0] IDX_B4          = 3'h4;
  localparam logic [2:0] IDX_B5          = 3'h5;
  localparam logic [2:0] IDX_B6          = 3'h6;

  // byte 4 fields
  localparam int SERIAL_BIT = 7;
  localparam int RX_BIT     = 6;
  localparam int TX_BIT     = 5;
  localparam int I2C_BIT    = 4;
  localparam int SUSP_BIT   = 3;
  localparam int CFG_BIT    = 2;
  localparam int SEC_HI     = 1;
  // byte 5 / byte 6 fields
  localparam int DIV_HI     = 4;
  localparam int REF_HI     = 7;
  localparam int REF_LO     = 6;
  localparam int REF_SRC    = 5;
  localparam int DAC_HI     = 4;
  localparam logic [7:0] DIV_MASK = 8'h1F;

  // security modes
  localparam logic [1:0] SEC_OPEN     = 2'h0;
  localparam logic [1:0] SEC_PASSWORD = 2'h1;

  // settings after reset
  localparam logic [7:0] SET4_RST = 8'h00;
  localparam logic [7:0] SET5_RST = 8'h00;
  localparam logic [7:0] SET6_RST = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_BUILD = 3'b010,
    ST_DONE  = 3'b100
  } build_state_t;

endpackage
`default_nettype wire

// ### include/reply_buf_if.sv
// write and read ports of the reply byte buffer
// assumes one clock shared by both sides
`timescale 1ns/1ps
`default_nettype none
interface reply_buf_if;
  logic       wr_en;
  logic [2:0] wr_addr;
  logic [7:0] wr_data;
  logic       rd_en;
  logic [2:0] rd_addr;
  logic [7:0] rd_data;

  modport ctrl (output wr_en, output wr_addr, output wr_data,
                output rd_en, output rd_addr, input rd_data);
  modport mem  (input wr_en, input wr_addr, input wr_data,
                input rd_en, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// ### rtl/reply_buf.sv
// eight-byte reply buffer with registered read data
// assumes clk and synchronous active-low reset_n
`timescale 1ns/1ps
`default_nettype none
module reply_buf (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // buffer ports
  reply_buf_if.mem  buf_port
);

  logic [7:0] mem_q [8];
  logic [7:0] rd_data_q;

  // byte store, write side
  always_ff @(posedge clk)
  begin
    if (buf_port.wr_en)
      mem_q[buf_port.wr_addr] <= buf_port.wr_data;
  end

  // read data register
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      rd_data_q <= 8'h00;
    else if (buf_port.rd_en)
      rd_data_q <= mem_q[buf_port.rd_addr];
  end

  assign buf_port.rd_data = rd_data_q;

endmodule
`default_nettype wire

// ### dv/chip_settings_monitor.sv
// port checker for chip_settings_readback
// assumes clk and synchronous active-low reset_n, bound below
`timescale 1ns/1ps
`default_nettype none
module chip_settings_monitor (
  // clock and reset
  input wire logic       clk,
  input wire logic       reset_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // conditions and enables
  input wire logic       uart_rx_active,
  input wire logic       uart_tx_active,
  input wire logic       i2c_active,
  input wire logic       usb_configured,
  input wire logic       i2c_indicator_en,
  input wire logic       suspend_indicator_en,
  input wire logic       configured_indicator_en,
  input wire logic       clock_out_en,
  // outputs
  input wire logic       rx_activity_indicator,
  input wire logic       tx_activity_indicator,
  input wire logic       i2c_activity_indicator,
  input wire logic       suspend_indicator,
  input wire logic       configured_indicator,
  input wire logic       clock_ref_out,
  input wire logic       serial_number_enable,
  input wire logic       config_locked,
  input wire logic       config_password_mode,
  input wire logic       settings_write_blocked,
  input wire logic [1:0] dac_ref_level,
  input wire logic       dac_ref_internal,
  input wire logic [4:0] dac_value
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [1:0] up_q;
  // two cycles since reset release, so $past never sees reset values
  always_ff @(posedge clk)
  begin
    up_q <= reset_n ? {up_q[0], 1'b1} : 2'b00;
  end
  a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  a_rx_invert: assert property (up_q[1] && !$past(reg_wr) && $changed(uart_rx_active)
    |=> $changed(rx_activity_indicator)) else $error("rx indicator missed activity");
  a_tx_invert: assert property (up_q[1] && !$past(reg_wr) && $changed(uart_tx_active)
    |=> $changed(tx_activity_indicator)) else $error("tx indicator missed activity");
  a_i2c_invert: assert property (up_q[1] && !$past(reg_wr) && i2c_indicator_en
    && $stable(i2c_indicator_en) && $changed(i2c_active) |=> $changed(i2c_activity_indicator))
    else $error("i2c indicator missed traffic");
  a_susp_gated: assert property (up_q[1] && !$past(reg_wr) && !suspend_indicator_en
    && !$past(suspend_indicator_en) |=> $stable(suspend_indicator)) else $error("suspend pin moved");
  a_cfg_invert: assert property (up_q[1] && !$past(reg_wr) && configured_indicator_en
    && $stable(configured_indicator_en) && $changed(usb_configured) |=> $changed(configured_indicator))
    else $error("configured indicator missed change");
  a_serial_view: assert property (reg_rd && reg_addr == 4'hA |=> serial_number_enable == reg_rdata[7])
    else $error("serial enable differs from setting");
  a_lock_view: assert property (reg_rd && reg_addr == 4'hA |=> config_locked == reg_rdata[1]
    && config_password_mode == (reg_rdata[1:0] == 2'b01)) else $error("lock mode differs");
  a_lock_blocks: assert property (config_locked && $past(config_locked) |-> settings_write_blocked)
    else $error("locked but writes open");
  a_div_mask: assert property (reg_rd && reg_addr == 4'hB |=> reg_rdata[7:5] == 3'b000)
    else $error("divider spare bits not zero");
  a_clock_off: assert property (up_q[1] && !clock_out_en && !$past(clock_out_en) |-> !clock_ref_out)
    else $error("clock output runs while disabled");
  a_dac_view: assert property (reg_rd && reg_addr == 4'hC |=> dac_ref_level == reg_rdata[7:6]
    && dac_ref_internal == reg_rdata[5]) else $error("dac reference differs");
  a_dac_hold: assert property (up_q[1] |-> $stable(dac_value))
    else $error("dac value changed after power-up");
endmodule
bind chip_settings_readback chip_settings_monitor mon (.*);
`default_nettype wire

// ### dv/usb_host_model.sv
// host model: configuration software on the register port
// assumes clk from the bench, read data one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
  // clock
  input  wire logic       clk,
  // register port
  output logic      [3:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  // marks a read whose data is compared
  output logic            rd_chk
);
  // ****
  // bus cycles
  // ****
  initial
  begin
    reg_addr <= 4'h0;
    reg_wdata <= 8'h00;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    rd_chk <= 1'b0;
  end
  // one-cycle write, data inverted once released
  task automatic put(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // one-cycle read, data taken in the following cycle
  task automatic get(input logic [3:0] a, input logic c, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rd_chk <= c;
    @(posedge clk);
    reg_rd <= 1'b0;
    rd_chk <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // read-flash request, then bounded poll for ready
  task automatic request(input logic [7:0] cmd, input logic [7:0] sub, output logic ok);
    logic [7:0] st;
    ok = 1'b0;
    put(4'h8, cmd);
    put(4'h9, sub);
    put(4'hD, 8'h01);
    for (int i = 0; i < 40 && !ok; i++)
    begin
      get(4'hD, 1'b0, st);
      ok = st[1];
    end
  endtask
endmodule
`default_nettype wire

// ### dv/test_chip_settings_readback.sv
// self-checking bench for chip_settings_readback
// assumes the host model drives the register port
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module test_chip_settings_readback;
  // ****
  // bench
  // ****
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       reg_wr;
  logic       reg_rd;
  logic       rd_chk;
  logic [9:0] cond = 10'h000; // pw_ok clk_en cfg_en susp_en i2c_en cfg susp i2c tx rx
  wire  [4:0] ind; // one output port drives each bit
  logic       ck;
  logic [4:0] dac_val;
  logic [7:0] s4, s5, s6;
  logic [7:0] exp_q[$];
  logic       rd_pend = 1'b0;
  int         checks = 0;
  int         n_errors = 0;
  always #5 clk = ~clk;
  usb_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rd_chk(rd_chk));
  chip_settings_readback dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .uart_rx_active(cond[0]),
    .uart_tx_active(cond[1]), .i2c_active(cond[2]), .usb_suspended(cond[3]), .usb_configured(cond[4]),
    .i2c_indicator_en(cond[5]), .suspend_indicator_en(cond[6]), .configured_indicator_en(cond[7]),
    .clock_out_en(cond[8]), .password_ok(cond[9]), .rx_activity_indicator(ind[0]),
    .tx_activity_indicator(ind[1]), .i2c_activity_indicator(ind[2]), .suspend_indicator(ind[3]),
    .configured_indicator(ind[4]), .clock_ref_out(ck), .serial_number_enable(), .config_locked(),
    .config_password_mode(), .settings_write_blocked(), .dac_ref_level(), .dac_ref_internal(),
    .dac_value(dac_val));
  // read data stands one cycle after a checked strobe
  always @(posedge clk) rd_pend <= reg_rd & rd_chk;
  always @(negedge clk)
    if (rd_pend)
    begin
      `CHECK(reg_rdata, exp_q.pop_front())
    end
  task automatic give_verdict();
    $display("n_errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // note the expected byte, then read it
  task automatic rd_exp(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    exp_q.push_back(e);
    host.get(a, 1'b1, d);
  endtask
  // issue a request and compare the whole reply
  task automatic reply(input logic [7:0] cmd, input logic [7:0] sub);
    logic ok;
    logic sup;
    sup = (cmd == 8'hB0) && (sub == 8'h00);
    host.request(cmd, sub, ok);
    if (!ok)
    begin
      n_errors++;
      give_verdict();
    end
    rd_exp(4'h0, cmd);
    rd_exp(4'h1, sup ? 8'h00 : 8'h01);
    rd_exp(4'h2, sup ? 8'h07 : 8'h00);
    rd_exp(4'h3, 8'h00);
    rd_exp(4'h4, sup ? s4 : 8'h00);
    rd_exp(4'h5, sup ? s5 : 8'h00);
    rd_exp(4'h6, sup ? s6 : 8'h00);
  endtask
  // random conditions, then every indicator against its idle bit
  task automatic ind_round();
    logic [9:0] c;
    c = {cond[9:8], 8'($urandom())};
    @(posedge clk);
    cond <= c;
    repeat (2) @(posedge clk);
    #1;
    `CHECK(ind[0], s4[6] ^ c[0])
    `CHECK(ind[1], s4[5] ^ c[1])
    `CHECK(ind[2], s4[4] ^ (c[5] & c[2]))
    `CHECK(ind[3], s4[3] ^ (c[6] & c[3]))
    `CHECK(ind[4], s4[2] ^ (c[7] & c[4]))
  endtask
  // toggles over four divided half periods
  task automatic clk_round(input logic [4:0] dv);
    int n;
    logic p;
    n = 0;
    host.put(4'hB, {3'b000, dv});
    cond[8] <= 1'b1;
    repeat (40) @(posedge clk);
    #1;
    p = ck;
    repeat (4 * (dv + 1))
    begin
      @(posedge clk);
      #1;
      n += (ck !== p);
      p = ck;
    end
    `CHECK(n, 4)
    s5 = {3'b000, dv};
  endtask
  initial
  begin
    void'($urandom(32'h89BE));
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    rd_exp(4'hA, 8'h00);
    rd_exp(4'hC, 8'h00);
    rd_exp(4'hE, 8'h00);
    rd_exp(4'hF, 8'h00);
    s4 = {6'($urandom()), 2'b00};
    s5 = 8'($urandom()) & 8'h1F;
    s6 = 8'($urandom());
    host.put(4'hA, s4);
    host.put(4'hB, s5 | 8'hE0);
    host.put(4'hC, s6);
    rd_exp(4'hA, s4);
    rd_exp(4'hB, s5);
    rd_exp(4'hC, s6);
    `CHECK(dac_val, 5'h00)
    reply(8'hB0, 8'h00);
    host.put(4'h0, 8'hFF);
    rd_exp(4'h0, 8'hB0);
    for (int i = 1; i < 8; i++)
      reply(8'hB0, (i == 7) ? 8'($urandom_range(255, 6)) : 8'(i));
    reply(8'hB1, 8'h00);
    repeat (40) ind_round();
    clk_round(5'h00);
    clk_round(5'h03);
    clk_round(5'h1F);
    cond[8] <= 1'b0;
    // password mode drops writes until the password is good
    s4[1:0] = 2'b01;
    host.put(4'hA, s4);
    host.put(4'hB, 8'h15);
    rd_exp(4'hB, s5);
    @(posedge clk);
    cond[9] <= 1'b1;
    host.put(4'hB, 8'h15);
    rd_exp(4'hB, 8'h15);
    host.put(4'hA, 8'h02);
    host.put(4'hA, 8'h00);
    rd_exp(4'hA, 8'h02);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    rd_exp(4'hA, 8'h00);
    // lock code 11 also freezes the settings
    host.put(4'hA, 8'h03);
    host.put(4'hA, 8'h00);
    rd_exp(4'hA, 8'h03);
    repeat (3) @(posedge clk);
    give_verdict();
  end
endmodule
`default_nettype wire
